// file: hdl/csc_pkg.sv
package csc_pkg;
    // device-issued command codes
    localparam logic [3:0] CMD_NOP             = 4'h0;
    localparam logic [3:0] CMD_LOCK            = 4'h1;
    localparam logic [3:0] CMD_FETCH           = 4'h2;
    localparam logic [3:0] CMD_FETCH_MOD       = 4'h3;
    localparam logic [3:0] CMD_ORDERING_BARRIER = 4'h4;
    localparam logic [3:0] CMD_SET_DIRTY       = 4'h5;
    localparam logic [3:0] CMD_WRITE_BLOCK     = 4'h6;
    localparam logic [3:0] CMD_WRITE_BLOCK_LOCK = 4'h7;
    localparam logic [3:0] CMD_MISS_EVEN       = 4'h8;
    localparam logic [3:0] CMD_MISS_ODD        = 4'h9;
    localparam logic [3:0] CMD_MISS_MOD_EVEN   = 4'hA;
    localparam logic [3:0] CMD_MISS_MOD_ODD    = 4'hB;
    localparam logic [3:0] CMD_VICTIM          = 4'hC;
    localparam logic [3:0] CMD_RESERVED        = 4'hD;
    localparam logic [3:0] CMD_MISS_CS_EVEN    = 4'hE;
    localparam logic [3:0] CMD_MISS_CS_ODD     = 4'hF;
    // low response bits for system commands
    localparam logic [1:0] RES_NOTHING         = 2'h0;
    localparam logic [1:0] RES_NO_HIT          = 2'h1;
    localparam logic [1:0] RES_FROM_L2         = 2'h2;
    localparam logic [1:0] RES_FROM_BOARD      = 2'h3;
    localparam logic [1:0] CLK_MODE_NORMAL     = 2'h0;
    localparam int         CMD_W               = 4;
    localparam int         RES_W               = 3;
    localparam int         RES_HIT_BIT         = 2;
endpackage

// file: hdl/csc_if.sv
`timescale 1ns/1ps
interface csc_if;
    logic [3:0] cmd_dev_out;   // device drive of the command bus
    logic       cmd_dev_oe;
    logic [3:0] cmd_sys_out;   // system drive of the command bus
    logic       cmd_sys_oe;
    logic [3:0] cmd_bus;       // resolved command bus level
    logic       cmd_ack;
    logic       cmd_fail;
    logic [2:0] addr_res;
    logic [1:0] clk_mode;

    // resolved level; an undriven bus reads as no operation
    assign cmd_bus = cmd_dev_oe ? cmd_dev_out : (cmd_sys_oe ? cmd_sys_out : 4'h0);

    modport dev (
        output cmd_dev_out,
        output cmd_dev_oe,
        input  cmd_bus,
        input  cmd_ack,
        input  cmd_fail,
        output addr_res,
        input  clk_mode
    );
    modport sys (
        output cmd_sys_out,
        output cmd_sys_oe,
        input  cmd_bus,
        output cmd_ack,
        output cmd_fail,
        input  addr_res,
        output clk_mode
    );
endinterface

// file: hdl/csc_dev_end.sv
`timescale 1ns/1ps
// Function
// - drive hit bit for each system command
// - system acknowledges every device command that it does not time out
// - ack with fail fails locked write
// - fail alone: timeout, partial reset, trap
// - clock mode inputs held deasserted normally
// - command bus shared both directions
// - codes nop, lock, ordering barrier
// - fetch hint codes 0010 and 0011
// - code 0101 requests set dirty
// - code 0110 requests block write
// - code 0111 requests locked block write
// - miss, victim codes; 1101 reserved
// - low response bits encode data source
module csc_dev_end (
    input  wire logic       clk,
    input  wire logic       rst_n,
    csc_if.dev              bus,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [3:0] req_cmd,
    output logic            done_pulse,
    output logic            done_ok,
    output logic            cond_write_failed,
    output logic            ibox_timeout,
    output logic            partial_reset,
    output logic            machine_check_trap,
    output logic            clk_mode_error,
    output logic            sys_cmd_valid,
    output logic [3:0]      sys_cmd,
    input  wire logic       hit_l2,
    input  wire logic       hit_lock_reg,
    input  wire logic       dirty_in_l2,
    input  wire logic       dirty_in_board
);
    typedef enum logic [0:0] {
        CSC_IDLE,
        CSC_WAIT
    } csc_state_t;

    csc_state_t state_reg, state_next;
    logic [3:0] cmd_reg, cmd_next;
    logic       done_reg, done_next;
    logic       ok_reg, ok_next;
    logic       cwf_reg, cwf_next;
    logic       tmo_reg, tmo_next;
    logic [2:0] res_reg, res_next;
    logic       svalid_reg, svalid_next;
    logic [3:0] scmd_reg, scmd_next;
    logic       cme_reg, cme_next;
    logic       outstanding;
    logic       answer_ack, answer_fail, locked_fail;
    logic       sys_cmd_seen;

    // codes the device may legally issue; reserved code is refused
    function automatic logic legal_cmd(input logic [3:0] c);
        legal_cmd = (c != csc_pkg::CMD_NOP) && (c != csc_pkg::CMD_RESERVED);
    endfunction

    // response bits for a system command from lookup results
    function automatic logic [2:0] sys_response(input logic l2, input logic lk,
                                               input logic dl2, input logic dbd);
        logic [1:0] low;
        logic       hit;
        // either lookup counts as a hit for the third bit
        hit = l2 | lk;
        low = csc_pkg::RES_NO_HIT;
        if (dl2) begin
            low = csc_pkg::RES_FROM_L2;
        end else if (dbd) begin
            low = csc_pkg::RES_FROM_BOARD;
        end
        sys_response = {hit, low};
    endfunction

    // one command at a time; nop and the reserved code are never taken
    assign outstanding = (state_reg == CSC_WAIT);
    assign req_ready   = !outstanding && legal_cmd(req_cmd);

    // answer decode; fail beside ack only matters for a locked write
    assign answer_ack  = outstanding && bus.cmd_ack;
    assign answer_fail = outstanding && !bus.cmd_ack && bus.cmd_fail;
    assign locked_fail = answer_ack && bus.cmd_fail
                         && (cmd_reg == csc_pkg::CMD_WRITE_BLOCK_LOCK);

    // issue sequence; a single command outstanding at a time
    always_comb begin
        state_next = state_reg;
        cmd_next   = cmd_reg;
        case (state_reg)
            CSC_IDLE: begin
                if (req_valid && legal_cmd(req_cmd)) begin
                    cmd_next   = req_cmd;
                    state_next = CSC_WAIT;
                end
            end
            CSC_WAIT: begin
                // stays outstanding until the system answers
                if (answer_ack || answer_fail) begin
                    state_next = CSC_IDLE;
                end
            end
            default: begin
                state_next = CSC_IDLE;
            end
        endcase
    end

    // issue state registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CSC_IDLE;
            cmd_reg   <= csc_pkg::CMD_NOP;
        end else begin
            state_reg <= state_next;
            cmd_reg   <= cmd_next;
        end
    end

    // completion result; flags pulse once, done_ok holds until the next answer
    always_comb begin
        done_next = answer_ack || answer_fail;
        ok_next   = ok_reg;
        cwf_next  = locked_fail;
        tmo_next  = answer_fail;
        if (answer_ack) begin
            ok_next = !locked_fail;
        end else if (answer_fail) begin
            ok_next = 1'b0;
        end
    end

    // result registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            ok_reg   <= 1'b0;
            cwf_reg  <= 1'b0;
            tmo_reg  <= 1'b0;
        end else begin
            done_reg <= done_next;
            ok_reg   <= ok_next;
            cwf_reg  <= cwf_next;
            tmo_reg  <= tmo_next;
        end
    end

    // drive own request only while outstanding; otherwise listen
    assign bus.cmd_dev_oe  = outstanding;
    assign bus.cmd_dev_out = cmd_reg;

    // a code on the bus that the device is not driving is the system's
    assign sys_cmd_seen = !bus.cmd_dev_oe && (bus.cmd_bus != csc_pkg::CMD_NOP);

    // system command capture and response; response lags one cycle
    always_comb begin
        svalid_next = 1'b0;
        scmd_next   = scmd_reg;
        res_next    = 3'h0;
        if (sys_cmd_seen) begin
            svalid_next = 1'b1;
            scmd_next   = bus.cmd_bus;
            res_next    = sys_response(hit_l2, hit_lock_reg, dirty_in_l2, dirty_in_board);
        end
    end

    // capture registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            svalid_reg <= 1'b0;
            scmd_reg   <= csc_pkg::CMD_NOP;
            res_reg    <= 3'h0;
        end else begin
            svalid_reg <= svalid_next;
            scmd_reg   <= scmd_next;
            res_reg    <= res_next;
        end
    end

    // clock mode watch; a level one cycle behind the mode pins
    always_comb begin
        cme_next = (bus.clk_mode != csc_pkg::CLK_MODE_NORMAL);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cme_reg <= 1'b0;
        end else begin
            cme_reg <= cme_next;
        end
    end

    // response bits toward the system
    assign bus.addr_res        = res_reg;

    // completion of own commands
    assign done_pulse          = done_reg;
    assign done_ok             = ok_reg;
    assign cond_write_failed   = cwf_reg;
    // the three timeout effects share one pulse so they never disagree
    assign ibox_timeout        = tmo_reg;
    assign partial_reset       = tmo_reg;
    assign machine_check_trap  = tmo_reg;

    // observed system commands and mode
    assign clk_mode_error      = cme_reg;
    assign sys_cmd_valid       = svalid_reg;
    assign sys_cmd             = scmd_reg;
endmodule

// file: hdl/csc_sys_end.sv
`timescale 1ns/1ps
// system-controller end: answers device commands, sends its own
module csc_sys_end (
    input  wire logic       clk,
    input  wire logic       rst_n,
    csc_if.sys              bus,
    input  wire logic       fail_locked_write,
    input  wire logic       force_timeout,
    input  wire logic       scmd_valid,
    output logic            scmd_ready,
    input  wire logic [3:0] scmd,
    output logic            dev_cmd_valid,
    output logic [3:0]      dev_cmd,
    output logic [2:0]      dev_response
);
    logic       ack_reg, ack_next;
    logic       fail_reg, fail_next;
    logic       vld_reg, vld_next;
    logic [3:0] dcmd_reg, dcmd_next;
    logic [3:0] sout_reg, sout_next;
    logic       soe_reg, soe_next;
    logic [2:0] resp_reg, resp_next;

    // one answer per device command, the cycle after it appears
    always_comb begin
        ack_next  = 1'b0;
        fail_next = 1'b0;
        vld_next  = 1'b0;
        dcmd_next = dcmd_reg;
        soe_next  = 1'b0;
        sout_next = csc_pkg::CMD_NOP;
        resp_next = bus.addr_res;
        if (bus.cmd_bus != csc_pkg::CMD_NOP && !soe_reg && !ack_reg && !fail_reg) begin
            vld_next  = 1'b1;
            dcmd_next = bus.cmd_bus;
            if (force_timeout) begin
                fail_next = 1'b1;
            end else begin
                ack_next  = 1'b1;
                fail_next = fail_locked_write
                            && bus.cmd_bus == csc_pkg::CMD_WRITE_BLOCK_LOCK;
            end
        end else if (scmd_valid && bus.cmd_bus == csc_pkg::CMD_NOP && !soe_reg) begin
            soe_next  = 1'b1;
            sout_next = scmd;
        end
    end

    assign scmd_ready = bus.cmd_bus == csc_pkg::CMD_NOP && !soe_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg  <= 1'b0;
            fail_reg <= 1'b0;
            vld_reg  <= 1'b0;
            dcmd_reg <= csc_pkg::CMD_NOP;
            soe_reg  <= 1'b0;
            sout_reg <= csc_pkg::CMD_NOP;
            resp_reg <= 3'h0;
        end else begin
            ack_reg  <= ack_next;
            fail_reg <= fail_next;
            vld_reg  <= vld_next;
            dcmd_reg <= dcmd_next;
            soe_reg  <= soe_next;
            sout_reg <= sout_next;
            resp_reg <= resp_next;
        end
    end

    assign bus.cmd_ack     = ack_reg;
    assign bus.cmd_fail    = fail_reg;
    assign bus.cmd_sys_oe  = soe_reg;
    assign bus.cmd_sys_out = sout_reg;
    assign bus.clk_mode    = csc_pkg::CLK_MODE_NORMAL;
    assign dev_cmd_valid   = vld_reg;
    assign dev_cmd         = dcmd_reg;
    assign dev_response    = resp_reg;
endmodule

// file: tb/csc_assertions.sv
`timescale 1ns/1ps
// watches both drivers of the shared command bus
module csc_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] cmd_dev_out,
    input wire logic       cmd_dev_oe,
    input wire logic       cmd_sys_oe,
    input wire logic [3:0] cmd_bus,
    input wire logic       cmd_ack,
    input wire logic       cmd_fail,
    input wire logic [2:0] addr_res,
    input wire logic [1:0] clk_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // device request lifetime on the bus
    ack_follows_cmd_a: assert property ($rose(cmd_dev_oe) |=> cmd_ack || cmd_fail)
        else $error("device command not answered in time");
    answer_needs_cmd_a: assert property (cmd_ack || cmd_fail |-> cmd_dev_oe)
        else $error("answer with no command on the bus");
    drive_held_a: assert property (cmd_dev_oe && !cmd_ack && !cmd_fail |=> cmd_dev_oe)
        else $error("command dropped before its answer");
    drive_released_a: assert property (cmd_dev_oe && (cmd_ack || cmd_fail) |=> !cmd_dev_oe)
        else $error("command still driven after its answer");
    code_stable_a: assert property (cmd_dev_oe && $past(cmd_dev_oe) |-> $stable(cmd_dev_out))
        else $error("command code changed while outstanding");
    code_legal_a: assert property (cmd_dev_oe |-> cmd_bus != 4'h0 && cmd_bus != 4'hD)
        else $error("nop or reserved code driven");
    // system command and its response
    sys_pulse_a: assert property (cmd_sys_oe |=> !cmd_sys_oe)
        else $error("system drive longer than one cycle");
    resp_given_a: assert property ($rose(cmd_sys_oe) && !cmd_dev_oe |=> addr_res[1:0] != 2'h0)
        else $error("system command got no response code");
    resp_idle_a: assert property (!$past(cmd_sys_oe) |-> addr_res == 3'h0)
        else $error("response driven with no system command");
    mode_normal_a: assert property (clk_mode == 2'h0)
        else $error("clock mode not deasserted");
endmodule

// file: tb/test_cpu_system_command_interface.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_cpu_system_command_interface;
    logic       clk = 1'b0, rst_n = 1'b0;
    logic       req_valid = 1'b0, fail_locked_write = 1'b0, force_timeout = 1'b0;
    logic [3:0] req_cmd = 4'h0, scmd = 4'h0, last_dev = 4'h0;
    logic       scmd_valid = 1'b0, hit_l2 = 1'b0, hit_lock_reg = 1'b0;
    logic       dirty_in_l2 = 1'b0, dirty_in_board = 1'b0;
    logic       req_ready, done_pulse, done_ok, cond_write_failed, ibox_timeout, clk_mode_error;
    logic       partial_reset, machine_check_trap, sys_cmd_valid, scmd_ready, dev_cmd_valid;
    logic [3:0] sys_cmd, dev_cmd;
    logic [2:0] dev_response;
    int         num_errors = 0, n_tests = 0, cycles = 0;

    always #5 clk = ~clk;

    csc_if ifc ();
    csc_dev_end u_csc_dev_end (.clk, .rst_n, .bus(ifc), .req_valid, .req_ready, .req_cmd,
        .done_pulse, .done_ok, .cond_write_failed, .ibox_timeout, .partial_reset,
        .machine_check_trap, .clk_mode_error, .sys_cmd_valid, .sys_cmd, .hit_l2,
        .hit_lock_reg, .dirty_in_l2, .dirty_in_board);
    csc_sys_end u_csc_sys_end (.clk, .rst_n, .bus(ifc), .fail_locked_write, .force_timeout,
        .scmd_valid, .scmd_ready, .scmd, .dev_cmd_valid, .dev_cmd, .dev_response);
    csc_assertions u_csc_assertions (.clk, .rst_n, .cmd_dev_out(ifc.cmd_dev_out),
        .cmd_dev_oe(ifc.cmd_dev_oe), .cmd_sys_oe(ifc.cmd_sys_oe), .cmd_bus(ifc.cmd_bus),
        .cmd_ack(ifc.cmd_ack), .cmd_fail(ifc.cmd_fail), .addr_res(ifc.addr_res),
        .clk_mode(ifc.clk_mode));

    task automatic results();
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // bounded wait, checked at falling edges where outputs are settled
    task automatic wait_hi(ref logic s);
        for (int k = 0; k < 20 && s !== 1'b1; k++) begin
            @(negedge clk);
        end
    endtask

    // expected response: hit bit, then l2 over board over not found
    function automatic logic [2:0] resp(input logic [3:0] h);
        resp[2] = h[3] | h[2];
        resp[1:0] = h[1] ? 2'h2 : (h[0] ? 2'h3 : 2'h1);
    endfunction

    // one device command; fl and ft steer how the system answers
    task automatic dev_op(input logic [3:0] c, input logic fl, input logic ft);
        logic [4:0] e;
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= c;
        fail_locked_write <= fl;
        force_timeout <= ft;
        @(negedge clk);
        wait_hi(req_ready);
        @(posedge clk);
        req_valid <= 1'b0;
        @(negedge clk);
        `CHK({req_ready, ifc.cmd_bus}, {1'b0, c})
        wait_hi(done_pulse);
        `CHK(done_pulse, 1'b1)
        `CHK(clk_mode_error, 1'b0)
        e[4] = !ft && !(fl && c == csc_pkg::CMD_WRITE_BLOCK_LOCK);
        e[3:0] = {!ft && !e[4], ft, ft, ft};
        `CHK({done_ok, cond_write_failed, ibox_timeout, partial_reset, machine_check_trap}, e)
        `CHK(last_dev, c)
    endtask

    // one system command with hit and dirty lookups held meanwhile
    task automatic sys_op(input logic [3:0] c, input logic [3:0] h);
        @(posedge clk);
        scmd_valid <= 1'b1;
        scmd <= c;
        {hit_l2, hit_lock_reg, dirty_in_l2, dirty_in_board} <= h;
        @(negedge clk);
        wait_hi(scmd_ready);
        @(posedge clk);
        scmd_valid <= 1'b0;
        @(negedge clk);
        wait_hi(sys_cmd_valid);
        `CHK({sys_cmd_valid, sys_cmd}, {1'b1, c})
        @(negedge clk);
        `CHK(dev_response, resp(h))
    endtask

    // system end's view of each device command
    always @(posedge clk) begin
        if (dev_cmd_valid === 1'b1) last_dev <= dev_cmd;
    end

    // hang guard; the whole sequence needs about 620 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            results();
        end
    end

    initial begin
        logic [3:0] c;
        void'($urandom(32'hE106D2DB));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // reserved and nop codes must never be taken
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd <= 4'hD;
        @(negedge clk);
        `CHK(req_ready, 1'b0)
        @(posedge clk);
        req_cmd <= 4'h0;
        @(negedge clk);
        `CHK({req_ready, ifc.cmd_bus}, 5'h00)
        // every legal code, with a locked-write failure pending
        for (int i = 1; i < 16; i++) begin
            if (i != 13) dev_op(4'(i), 1'b1, 1'b0);
        end
        dev_op(4'h4, 1'b0, 1'b1);
        dev_op(4'h7, 1'b1, 1'b1);
        for (int h = 0; h < 16; h++) begin
            sys_op(4'h1 + 4'(h % 5), 4'(h));
        end
        // random mix back to back
        repeat (60) begin
            c = 4'($urandom % 15) + 4'h1;
            if (c == 4'hD) c = 4'h7;
            dev_op(c, 1'($urandom), 1'($urandom % 8 == 0));
            sys_op(4'($urandom % 5) + 4'h1, 4'($urandom));
        end
        results();
    end
endmodule
